// ---- pcix_status_pkg.sv ----
// constants for the bridge capability and status register bank
package pcix_status_pkg;

  // ---------------------------------------------------------------
  // register byte addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] BUS_NUMBER_ADDR = 8'h18;
  localparam logic [7:0] SECONDARY_SIDE_STATUS_ADDR = 8'h50;
  localparam logic [7:0] BRIDGE_PRIMARY_STATUS_ADDR = 8'h54;
  localparam logic [7:0] UPSTREAM_SPLIT_CONTROL_ADDR = 8'h58;
  localparam logic [7:0] IRQ_STATUS_ADDR = 8'h70;
  localparam logic [7:0] IRQ_MASK_ADDR = 8'h74;

  // ---------------------------------------------------------------
  // secondary side status field positions
  // ---------------------------------------------------------------
  localparam int WIDE_BUS_FLAG_BIT = 0;
  localparam int CAPABLE_133_FLAG_BIT = 1;
  localparam int COMPLETION_DISCARDED_FLAG_BIT = 2;

  // ---------------------------------------------------------------
  // bridge primary status field positions
  // ---------------------------------------------------------------
  localparam int FUNCTION_NUMBER_LSB = 0;
  localparam int DEVICE_NUMBER_LSB = 3;
  localparam int BUS_NUMBER_LSB = 8;
  localparam int PRIMARY_WIDE_BIT = 16;
  localparam int PRIMARY_133_BIT = 17;
  localparam int PRIMARY_DISCARDED_BIT = 18;
  localparam int UNEXPECTED_COMPLETION_BIT = 19;
  localparam int COMPLETION_OVERRUN_BIT = 20;
  localparam int REQUEST_DELAYED_BIT = 21;

  // ---------------------------------------------------------------
  // upstream split control fields and reset values
  // ---------------------------------------------------------------
  localparam int SPLIT_LIMIT_LSB = 16;
  localparam logic [15:0] SPLIT_CAPACITY_VALUE = 16'hffff;
  localparam logic [15:0] SPLIT_LIMIT_RESET = 16'h0000;
  localparam logic [31:0] BRIDGE_STATUS_RESET = 32'h0001_00f8;
  localparam logic [31:0] SPLIT_CONTROL_RESET = 32'h0000_ffff;
  localparam logic [7:0] BUS_NUMBER_RESET = 8'h00;

  // device numbers of the two bus instances
  localparam logic [4:0] DEVICE_NUMBER_FIRST = 5'h1f;
  localparam logic [4:0] DEVICE_NUMBER_SECOND = 5'h1d;
  localparam logic [2:0] FUNCTION_NUMBER_VALUE = 3'h0;

  // ---------------------------------------------------------------
  // interrupt bits and split launch buffering
  // ---------------------------------------------------------------
  localparam int IRQ_DISCARD_BIT = 0;
  localparam int IRQ_WIDTH = 1;
  localparam int CREDIT_WIDTH = 4;
  localparam logic [3:0] BUFFER_SLOTS = 4'h8;

endpackage

// ---- pcix_bridge_capability_status.sv ----
// bridge capability, status and upstream split control register bank
//
// Summary of operation
// - a split completion dropped on its way to the secondary bus sets the discarded flag, bit 2.
// - the discarded flag clears when software writes a one to it; a zero leaves it alone.
// - bit 1 of the secondary status always reads one for 133 MHz capability.
// - bit 0 of the secondary status always reads one for a 64-bit secondary bus.
// - bit 21 of the bridge status, request delayed, always reads zero.
// - bit 20 of the bridge status, completion overrun, always reads zero.
// - bits 19 and 18 of the bridge status always read zero.
// - bit 17 of the bridge status, primary 133 MHz capability, always reads zero.
// - bit 16 of the bridge status always reads one for a 64-bit primary interface.
// - bits 15:8 of the bridge status mirror the primary bus number held at 18h.
// - bits 7:3 of the bridge status give the device number, 1Fh first instance, 1Dh second.
// - bits 2:0 of the bridge status give a read-only function number.
// - bits 31:16 of the upstream split control are plain storage that steers nothing.
// - bits 15:0 of the upstream split control read as all ones.
// - upstream split launches are gated by free buffer slots, whatever the limit says.
module pcix_bridge_capability_status #(
  parameter bit SECOND_INSTANCE = 1'b0  // 0 first bus instance, 1 second
) (
  input wire logic clk,  // 125 MHz core clock
  input wire logic reset,  // asynchronous, active high
  input wire logic wb_cyc_i,  // wishbone cycle
  input wire logic wb_stb_i,  // wishbone strobe
  input wire logic wb_we_i,  // wishbone write enable
  input wire logic [7:0] wb_adr_i,  // byte address
  input wire logic [3:0] wb_sel_i,  // byte lane selects
  input wire logic [31:0] wb_dat_i,  // write data
  output logic [31:0] wb_dat_o,  // read data, registered
  output logic wb_ack_o,  // one-cycle acknowledge
  input wire logic completion_discard_event,  // pulse: completion dropped
  input wire logic split_launch_req,  // upstream split wants to launch
  output logic split_launch_grant,  // launch allowed this cycle
  input wire logic split_slot_return,  // pulse: a buffer slot freed
  output logic irq  // level interrupt
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic discarded;
    logic [15:0] split_limit;
    logic [7:0] primary_bus_number;
    logic [pcix_status_pkg::IRQ_WIDTH-1:0] irq_status;
    logic [pcix_status_pkg::IRQ_WIDTH-1:0] irq_mask;
    logic [pcix_status_pkg::CREDIT_WIDTH-1:0] credits;
  } state_t;

  state_t state_reg;
  state_t state_next;

  logic access;
  logic wr;
  logic [31:0] read_value;
  logic [31:0] secondary_word;
  logic [31:0] bridge_word;
  logic [31:0] split_word;
  logic [4:0] device_number;
  logic [31:0] byte_mask;

  // ---------------------------------------------------------------
  // read views of the documented registers
  // ---------------------------------------------------------------
  // device number is a strap of the instance, not writable
  assign device_number = SECOND_INSTANCE ? pcix_status_pkg::DEVICE_NUMBER_SECOND
                                         : pcix_status_pkg::DEVICE_NUMBER_FIRST;

  // secondary status: low capability bits hardwired, flag from state
  always_comb
  begin
    secondary_word = 32'h0000_0000;
    secondary_word[pcix_status_pkg::WIDE_BUS_FLAG_BIT] = 1'b1;
    secondary_word[pcix_status_pkg::CAPABLE_133_FLAG_BIT] = 1'b1;
    secondary_word[pcix_status_pkg::COMPLETION_DISCARDED_FLAG_BIT] = state_reg.discarded;
  end

  // bridge status: only the bus number changes at run time
  always_comb
  begin
    bridge_word = 32'h0000_0000;
    bridge_word[pcix_status_pkg::PRIMARY_WIDE_BIT] = 1'b1;
    bridge_word[pcix_status_pkg::BUS_NUMBER_LSB +: 8] = state_reg.primary_bus_number;
    bridge_word[pcix_status_pkg::DEVICE_NUMBER_LSB +: 5] = device_number;
    bridge_word[pcix_status_pkg::FUNCTION_NUMBER_LSB +: 3] =
      pcix_status_pkg::FUNCTION_NUMBER_VALUE;
  end

  // split control: limit is storage, capacity hardwired to all ones
  assign split_word = {state_reg.split_limit, pcix_status_pkg::SPLIT_CAPACITY_VALUE};

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  // ack registered so every access takes exactly one wait cycle
  assign access = wb_cyc_i && wb_stb_i && !state_reg.ack;
  assign wr = access && wb_we_i;
  assign byte_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  // unmapped addresses read zero and swallow writes
  always_comb
  begin
    if (wb_adr_i == pcix_status_pkg::BUS_NUMBER_ADDR)
      read_value = {24'h00_0000, state_reg.primary_bus_number};
    else if (wb_adr_i == pcix_status_pkg::SECONDARY_SIDE_STATUS_ADDR)
      read_value = secondary_word;
    else if (wb_adr_i == pcix_status_pkg::BRIDGE_PRIMARY_STATUS_ADDR)
      read_value = bridge_word;
    else if (wb_adr_i == pcix_status_pkg::UPSTREAM_SPLIT_CONTROL_ADDR)
      read_value = split_word;
    else if (wb_adr_i == pcix_status_pkg::IRQ_STATUS_ADDR)
      read_value = {31'h0000_0000, state_reg.irq_status};
    else if (wb_adr_i == pcix_status_pkg::IRQ_MASK_ADDR)
      read_value = {31'h0000_0000, state_reg.irq_mask};
    else
      read_value = 32'h0000_0000;
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb
  begin
    state_next = state_reg;
    state_next.ack = access;
    if (access)
      state_next.rdata = wb_we_i ? 32'h0000_0000 : read_value;
    // discarded flag: clear first so a same-cycle event wins
    if (wr && wb_adr_i == pcix_status_pkg::SECONDARY_SIDE_STATUS_ADDR && wb_sel_i[0]
        && wb_dat_i[pcix_status_pkg::COMPLETION_DISCARDED_FLAG_BIT])
      state_next.discarded = 1'b0;
    if (completion_discard_event)
      state_next.discarded = 1'b1;
    // interrupt status, same set-over-clear ordering
    if (wr && wb_adr_i == pcix_status_pkg::IRQ_STATUS_ADDR && wb_sel_i[0])
      state_next.irq_status = state_reg.irq_status & ~wb_dat_i[0];
    if (completion_discard_event)
      state_next.irq_status[pcix_status_pkg::IRQ_DISCARD_BIT] = 1'b1;
    if (wr && wb_adr_i == pcix_status_pkg::IRQ_MASK_ADDR && wb_sel_i[0])
      state_next.irq_mask = wb_dat_i[0];
    // only the limit half of split control takes write data
    if (wr && wb_adr_i == pcix_status_pkg::UPSTREAM_SPLIT_CONTROL_ADDR)
      state_next.split_limit = (state_reg.split_limit & ~byte_mask[31:16])
                             | (wb_dat_i[31:16] & byte_mask[31:16]);
    if (wr && wb_adr_i == pcix_status_pkg::BUS_NUMBER_ADDR && wb_sel_i[0])
      state_next.primary_bus_number = wb_dat_i[7:0];
    // slot accounting; the split limit never enters here
    if (split_launch_grant && !split_slot_return)
      state_next.credits = state_reg.credits - 4'h1;
    else if (!split_launch_grant && split_slot_return
             && state_reg.credits != pcix_status_pkg::BUFFER_SLOTS)
      state_next.credits = state_reg.credits + 4'h1;
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      state_reg.ack <= 1'b0;
      state_reg.rdata <= 32'h0000_0000;
      state_reg.discarded <= 1'b0;
      state_reg.split_limit <= pcix_status_pkg::SPLIT_LIMIT_RESET;
      state_reg.primary_bus_number <= pcix_status_pkg::BUS_NUMBER_RESET;
      state_reg.irq_status <= 1'b0;
      state_reg.irq_mask <= 1'b0;
      state_reg.credits <= pcix_status_pkg::BUFFER_SLOTS;
    end
    else
      state_reg <= state_next;
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign wb_ack_o = state_reg.ack;
  assign wb_dat_o = state_reg.rdata;
  assign irq = |(state_reg.irq_status & state_reg.irq_mask);
  // a launch needs a free slot; an overfull buffer cannot happen
  assign split_launch_grant = split_launch_req && state_reg.credits != 4'h0;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  logic rd_sec;
  logic rd_bri;
  logic rd_spl;
  assign rd_sec = access && !wb_we_i && wb_adr_i == pcix_status_pkg::SECONDARY_SIDE_STATUS_ADDR;
  assign rd_bri = access && !wb_we_i && wb_adr_i == pcix_status_pkg::BRIDGE_PRIMARY_STATUS_ADDR;
  assign rd_spl = access && !wb_we_i && wb_adr_i == pcix_status_pkg::UPSTREAM_SPLIT_CONTROL_ADDR;

  a_discard_sets_flag: assert property (completion_discard_event |=> state_reg.discarded)
    else $error("discard event did not set flag");
  a_zero_write_keeps: assert property (
    wr && wb_adr_i == pcix_status_pkg::SECONDARY_SIDE_STATUS_ADDR && !wb_dat_i[2]
    && state_reg.discarded |=> state_reg.discarded)
    else $error("writing zero cleared flag");
  a_one_write_clears: assert property (
    wr && wb_adr_i == pcix_status_pkg::SECONDARY_SIDE_STATUS_ADDR && wb_sel_i[0] && wb_dat_i[2]
    && !completion_discard_event |=> !state_reg.discarded)
    else $error("writing one did not clear flag");
  a_secondary_hard_bits: assert property (rd_sec |=> wb_ack_o && wb_dat_o[1:0] == 2'b11)
    else $error("secondary capability bits wrong");
  a_secondary_wide_bit: assert property (rd_sec |=> wb_dat_o[0])
    else $error("secondary wide bit not one");
  a_bridge_zero_bits: assert property (rd_bri |=> wb_dat_o[21:17] == 5'h00)
    else $error("bridge hardwired zero bits set");
  a_bridge_wide_bit: assert property (rd_bri |=> wb_dat_o[16])
    else $error("bridge wide bit not one");
  a_bus_number_alias: assert property (
    rd_bri |=> wb_dat_o[15:8] == $past(state_reg.primary_bus_number))
    else $error("bus number alias mismatch");
  a_device_function: assert property (
    rd_bri |=> wb_dat_o[7:0] == {device_number, pcix_status_pkg::FUNCTION_NUMBER_VALUE})
    else $error("device or function number wrong");
  a_split_capacity: assert property (rd_spl |=> wb_dat_o[15:0] == 16'hffff)
    else $error("split capacity not all ones");
  a_limit_no_effect: assert property (
    split_launch_req && state_reg.credits != 4'h0 |-> split_launch_grant)
    else $error("launch blocked with free slots");
  a_no_overallocate: assert property (state_reg.credits == 4'h0 |-> !split_launch_grant)
    else $error("launch granted without slot");

  c_discard_irq: cover property (completion_discard_event ##1 irq);
  c_flag_cleared: cover property (state_reg.discarded ##1 !state_reg.discarded);
  c_slots_exhausted: cover property (split_launch_req && !split_launch_grant);

endmodule

// ---- pcix_bridge_capability_status_tb.sv ----
// self-checking bench for the capability, status and split control register bank
`define CHK(name, exp, got) \
  begin \
    cmp_count++; \
    if ((got) !== (exp)) \
    begin \
      $display("[FAIL] %s expected %h seen %h", name, exp, got); \
      n_errors++; \
    end \
  end
module pcix_bridge_capability_status_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk;
  logic reset;
  logic wb_cyc_i;
  logic wb_stb_i;
  logic wb_we_i;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic completion_discard_event;
  logic split_launch_req;
  logic split_launch_grant;
  logic split_slot_return;
  logic irq;
  int n_errors = 0;
  int cmp_count = 0;
  int grants;

  pcix_bridge_capability_status #(.SECOND_INSTANCE(1'b0)) i_dut (
    .clk(clk), .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .completion_discard_event(completion_discard_event),
    .split_launch_req(split_launch_req), .split_launch_grant(split_launch_grant),
    .split_slot_return(split_slot_return), .irq(irq)
  );

  // ---------------------------------------------------------------
  // clock, verdict and helpers
  // ---------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // expected bridge status word for a given primary bus number
  function automatic logic [31:0] bsts(input logic [7:0] bus);
    return {15'h0000, 1'b1, bus, pcix_status_pkg::DEVICE_NUMBER_FIRST,
            pcix_status_pkg::FUNCTION_NUMBER_VALUE};
  endfunction

  // one classic cycle; ack and read data are taken at the rising edge that ends it
  task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [3:0] sel,
                         input logic [31:0] wd, output logic [31:0] rdat);
    int n;
    n = 0;
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= sel;
    wb_dat_i <= wd;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 50);
    // a missing ack is a mismatch of its own
    if (wb_ack_o !== 1'b1)
    begin
      $display("[FAIL] bus ack expected 1 seen %b", wb_ack_o);
      n_errors++;
    end
    rdat = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] adr, input logic [3:0] sel, input logic [31:0] wd);
    logic [31:0] unused;
    wb_xfer(1'b1, adr, sel, wd, unused);
  endtask

  task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp, input string name);
    logic [31:0] got;
    wb_xfer(1'b0, adr, 4'hf, 32'h0000_0000, got);
    `CHK(name, exp, got)
  endtask

  // single-cycle pulse of the dropped-completion input
  task automatic discard();
    @(posedge clk);
    completion_discard_event <= 1'b1;
    @(posedge clk);
    completion_discard_event <= 1'b0;
  endtask

  // watchdog: the whole sequence needs well under a thousand cycles
  initial
  begin
    repeat (4000) @(posedge clk);
    n_errors++;
    results();
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    reset = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0000_0000;
    completion_discard_event = 1'b0;
    split_launch_req = 1'b0;
    split_slot_return = 1'b0;
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    // reset values and hardwired bits
    rd_chk(8'h54, bsts(8'h00), "bridge status reset");
    rd_chk(8'h58, 32'h0000_ffff, "split control reset");
    rd_chk(8'h50, 32'h0000_0003, "secondary status reset");
    // writes into read-only places must not stick
    wr(8'h54, 4'hf, 32'hffff_ffff);
    rd_chk(8'h54, bsts(8'h00), "bridge status after write");
    wr(8'h50, 4'hf, 32'hffff_fff8);
    rd_chk(8'h50, 32'h0000_0003, "secondary status after write");
    rd_chk(8'h40, 32'h0000_0000, "unmapped read");
    // bus number alias and split limit storage, partial lanes too
    wr(8'h18, 4'hf, 32'h0000_00a5);
    rd_chk(8'h54, bsts(8'ha5), "bus number alias");
    wr(8'h58, 4'hf, 32'h1234_0000);
    rd_chk(8'h58, 32'h1234_ffff, "split limit stored");
    wr(8'h58, 4'h3, 32'hffff_0000);
    rd_chk(8'h58, 32'h1234_ffff, "split low lanes");
    // dropped completion, sticky flag, interrupt and its mask
    wr(8'h74, 4'hf, 32'h0000_0001);
    rd_chk(8'h74, 32'h0000_0001, "irq mask stored");
    discard();
    @(negedge clk);
    `CHK("irq after discard", 1'b1, irq)
    rd_chk(8'h50, 32'h0000_0007, "discard flag set");
    rd_chk(8'h70, 32'h0000_0001, "irq status set");
    wr(8'h50, 4'hf, 32'h0000_0000);
    rd_chk(8'h50, 32'h0000_0007, "flag kept on zero write");
    wr(8'h50, 4'hf, 32'h0000_0004);
    rd_chk(8'h50, 32'h0000_0003, "flag cleared");
    wr(8'h70, 4'hf, 32'h0000_0001);
    @(negedge clk);
    `CHK("irq after clear", 1'b0, irq)
    wr(8'h74, 4'hf, 32'h0000_0000);
    discard();
    @(negedge clk);
    `CHK("masked irq", 1'b0, irq)
    rd_chk(8'h50, 32'h0000_0007, "flag set while masked");
    // launch gating: the pool runs dry whatever the programmed limit says
    grants = 0;
    @(posedge clk);
    split_launch_req <= 1'b1;
    repeat (12)
    begin
      @(negedge clk);
      if (split_launch_grant === 1'b1)
        grants++;
    end
    `CHK("grants from full pool", 8, grants)
    `CHK("grant held off", 1'b0, split_launch_grant)
    @(posedge clk);
    split_slot_return <= 1'b1;
    @(posedge clk);
    split_slot_return <= 1'b0;
    @(negedge clk);
    `CHK("grant after return", 1'b1, split_launch_grant)
    @(negedge clk);
    `CHK("slot used again", 1'b0, split_launch_grant)
    @(posedge clk);
    split_launch_req <= 1'b0;
    results();
  end
endmodule
